// file: hw/qbm_pkg.sv
/*
 * Constants for the queue, self-test, station management and EEPROM
 * register group: register offsets, field positions, reset images,
 * mode and operation codes, serial frame constants and timing.
 * Assumes a 40 MHz system clock and a classic Wishbone register bus.
 */
// How it works
// RULE1 - Writing one to transfer bit moves receive head block to transmit queue three.
// RULE2 - Queue logic clears the transfer bit itself when the move has finished.
// RULE3 - Writing one to disposition bit drops the whole current receive frame.
// RULE4 - Head status bit 17 shows head block ends frame; resets to one.
// RULE5 - Head status bit 16 shows head block ends a truncated frame.
// RULE6 - Head status gives next block index in 14:8, valid bytes in 7:0.
// RULE7 - Data status bit 24 set when next word read ends its frame.
// RULE8 - Data status bit 16 set while receive queue is empty; resets to one.
// RULE9 - Data status bits 1:0 give valid bytes in next word read.
// RULE10 - Writing one to self-test bit 31 launches the selected memory test.
// RULE11 - Bit 30 reports test failure, bit 29 pass; pass resets one, fail zero.
// RULE12 - With bit 20 set, memory address steps after each bypass access.
// RULE13 - Bit 19 enables self-test operation of the queue memory.
// RULE14 - Mode field: pattern, fill zeros, check zeros, fill ones, check ones, bypass.
// RULE15 - Bits 13:0 hold the queue memory word address for bypass accesses.
// RULE16 - Bypass data register reaches the memory word only in bypass mode.
// RULE17 - Management data low 16 bits hold PHY write value or read result.
// RULE18 - Management bit 12 set omits the 32-bit preamble, else it is sent.
// RULE19 - Management bit 11 starts a PHY transfer; hardware clears it when done.
// RULE20 - Management bit 10 one writes the PHY register, zero reads it back.
// RULE21 - Management bits 9:5 select PHY address, bits 4:0 the register.
// RULE22 - EEPROM data low 16 bits carry the word written or read back.
// RULE23 - EEPROM control bit 8 starts the operation; hardware clears it when done.
// RULE24 - EEPROM opcode: 11 erase, 10 read, 01 write, 00 enable or disable writes.
// RULE25 - PHY transfers use the standard management frame with turnaround and data.
// RULE26 - Software waits for management busy to clear before next transfer or read.
package qbm_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [8:0] ADR_XFER = 9'h128;
  localparam logic [8:0] ADR_DROP = 9'h12c;
  localparam logic [8:0] ADR_HEAD = 9'h130;
  localparam logic [8:0] ADR_RDS = 9'h134;
  localparam logic [8:0] ADR_BCR = 9'h138;
  localparam logic [8:0] ADR_BYP = 9'h13c;
  localparam logic [8:0] ADR_MDD = 9'h140;
  localparam logic [8:0] ADR_MDC = 9'h144;
  localparam logic [8:0] ADR_EED = 9'h148;
  localparam logic [8:0] ADR_EEC = 9'h14c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int XFER_GO = 0;
  localparam int DROP_GO = 0;
  localparam int HD_EOF = 17;
  localparam int HD_TRUNC = 16;
  localparam int HD_NEXT = 8;
  localparam int HD_USED = 0;
  localparam int RD_EOF = 24;
  localparam int RD_EMPTY = 16;
  localparam int RD_SIZE = 0;
  localparam int BC_START = 31;
  localparam int BC_FAIL = 30;
  localparam int BC_PASS = 29;
  localparam int BC_AUTO = 20;
  localparam int BC_EN = 19;
  localparam int BC_MODE = 16;
  localparam int BC_ADDR = 0;
  localparam int MC_NOPRE = 12;
  localparam int MC_BUSY = 11;
  localparam int MC_WR = 10;
  localparam int MC_PHY = 5;
  localparam int MC_REG = 0;
  localparam int EC_BUSY = 8;
  localparam int EC_OP = 6;
  localparam int EC_ADDR = 0;

  // ****************************************
  // Reset images
  // ****************************************
  localparam logic [31:0] HEAD_RST = 32'h0002_0000;
  localparam logic [31:0] RDS_RST = 32'h0001_0000;
  localparam logic [31:0] BCR_RST = 32'h2010_0000;

  // ****************************************
  // Modes, opcodes, frame constants
  // ****************************************
  localparam logic [2:0] MODE_PAT = 3'h1;
  localparam logic [2:0] MODE_FILL0 = 3'h2;
  localparam logic [2:0] MODE_READ0 = 3'h3;
  localparam logic [2:0] MODE_FILL1 = 3'h4;
  localparam logic [2:0] MODE_READ1 = 3'h5;
  localparam logic [2:0] MODE_BYPASS = 3'h6;
  localparam logic [31:0] PAT_EVEN = 32'h5555_5555;
  localparam logic [31:0] PAT_ODD = 32'haaaa_aaaa;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_WREN = 2'h0;
  localparam logic [1:0] MD_ST = 2'h1;
  localparam logic [1:0] MD_OP_WR = 2'h1;
  localparam logic [1:0] MD_OP_RD = 2'h2;
  localparam logic [1:0] MD_TA_WR = 2'h2;
  localparam logic [31:0] MD_PRE = 32'hffff_ffff;
  localparam logic [6:0] MD_BITS_PRE = 7'h40;
  localparam logic [6:0] MD_BITS = 7'h20;
  localparam logic [6:0] MD_TA_LEFT = 7'h12;
  localparam logic [6:0] MD_DATA_LEFT = 7'h10;
  localparam logic [4:0] EE_BITS_CMD = 5'h09;
  localparam logic [4:0] EE_BITS_DATA = 5'h19;
  localparam logic [4:0] EE_DATA_LEFT = 5'h10;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 25;
  localparam int SER_HALF_NS = 250;
  localparam int SER_HALF_CYC = (SER_HALF_NS + CLK_NS - 1) / CLK_NS;

endpackage : qbm_pkg

// file: hw/qbm_regs.sv
/*
 * Control register group: receive queue transfer and drop commands,
 * receive head block and data status, queue memory self-test with
 * bypass access, PHY station management engine and EEPROM engine.
 * Assumes queue logic and queue memory on the same clock; memory read
 * data valid in the cycle after mem_re_o is high.
 */
`timescale 1ns/1ps
module qbm_regs
  import qbm_pkg::*;
#(
  parameter int MEM_WORDS = 16384
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic [8:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Receive queue logic
  input wire logic head_eof_i,
  input wire logic head_trunc_i,
  input wire logic [6:0] head_next_i,
  input wire logic [7:0] head_used_i,
  input wire logic rd_eof_i,
  input wire logic rd_empty_i,
  input wire logic [1:0] rd_size_i,
  input wire logic xfer_done_i,
  output logic xfer_req_o,
  output logic drop_frame_o,
  // Queue memory
  input wire logic [31:0] mem_rdata_i,
  output logic [13:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  output logic mem_we_o,
  output logic mem_re_o,
  output logic mem_test_o,
  // PHY management link
  input wire logic mdio_i,
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_n_o,
  // Serial EEPROM
  input wire logic ee_do_i,
  output logic ee_cs_o,
  output logic ee_sk_o,
  output logic ee_di_o
);

  // ****************************************
  // State
  // ****************************************
  localparam int DIVW = $clog2(SER_HALF_CYC + 1);
  localparam logic [DIVW-1:0] DIV_LAST = DIVW'(SER_HALF_CYC - 1);
  localparam logic [13:0] LAST_ADDR = 14'(MEM_WORDS - 1);

  typedef enum logic [2:0] {B_IDLE, B_WR, B_RD, B_W1, B_CHK} qbm_bist_t;
  typedef enum logic [1:0] {W_IDLE, W_RD1, W_RD2} qbm_wb_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    qbm_wb_t wst;
    logic xfer;
    logic drop;
    logic [31:0] head_img;
    logic [31:0] rd_img;
    logic auto_inc;
    logic bist_en;
    logic [2:0] mode;
    logic [13:0] ram_addr;
    logic pass;
    logic fail;
    qbm_bist_t bst;
    logic [13:0] baddr;
    logic berr;
    logic mem_we;
    logic mem_re;
    logic [13:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [15:0] md_data;
    logic [12:0] md_ctl;
    logic [63:0] md_sh;
    logic [6:0] md_cnt;
    logic mdc;
    logic mdio;
    logic mdio_oe_n;
    logic [2:0] md_s;
    logic md_f;
    logic [15:0] ee_data;
    logic [8:0] ee_ctl;
    logic [24:0] ee_sh;
    logic [4:0] ee_cnt;
    logic sk;
    logic cs;
    logic di;
    logic [2:0] ee_s;
    logic ee_f;
    logic [DIVW-1:0] div;
    logic tick;
  } qbm_state_t;

  localparam qbm_state_t S_RST = '{wst: W_IDLE, bst: B_IDLE, head_img: HEAD_RST, rd_img: RDS_RST,
    pass: BCR_RST[BC_PASS], auto_inc: BCR_RST[BC_AUTO], mdio_oe_n: 1'b1, default: '0};

  qbm_state_t s;
  qbm_state_t next_s;

  function automatic logic [31:0] qbm_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : qbm_merge

  function automatic logic qbm_fills(input logic [2:0] m);
    return (m == MODE_PAT) || (m == MODE_FILL0) || (m == MODE_FILL1);
  endfunction : qbm_fills

  function automatic logic qbm_checks(input logic [2:0] m);
    return (m == MODE_PAT) || (m == MODE_READ0) || (m == MODE_READ1);
  endfunction : qbm_checks

  logic bus_req;
  logic byp_ok;
  assign bus_req = cyc_i & stb_i & ~s.ack & (s.wst == W_IDLE);
  assign byp_ok = (s.mode == MODE_BYPASS) && (s.bst == B_IDLE);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [31:0] rimg;
    logic [31:0] bcr_img;
    logic [31:0] wv;
    logic [31:0] bexp;
    logic [31:0] md_frame;
    logic adv;
    logic err_n;
    next_s = s;
    rimg = '0;
    wv = '0;
    adv = 1'b0;
    err_n = s.berr;
    md_frame = '0;
    bexp = '0;
    next_s.ack = 1'b0;
    next_s.drop = 1'b0;
    next_s.mem_we = 1'b0;
    next_s.mem_re = 1'b0;
    next_s.tick = 1'b0;
    bcr_img = '0;
    bcr_img[BC_FAIL] = s.fail;
    bcr_img[BC_PASS] = s.pass;
    bcr_img[BC_AUTO] = s.auto_inc;
    bcr_img[BC_EN] = s.bist_en;
    bcr_img[BC_MODE +: 3] = s.mode;
    bcr_img[BC_ADDR +: 14] = s.ram_addr;

    // Shared serial bit clock divider
    if (s.div == DIV_LAST) begin
      next_s.div = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = s.div + 1'b1;
    end

    // Status images follow the queue logic every cycle
    next_s.head_img = '0;
    next_s.head_img[HD_EOF] = head_eof_i; // [RULE4]
    next_s.head_img[HD_TRUNC] = head_trunc_i; // [RULE5]
    next_s.head_img[HD_NEXT +: 7] = head_next_i; // [RULE6]
    next_s.head_img[HD_USED +: 8] = head_used_i; // [RULE6]
    next_s.rd_img = '0;
    next_s.rd_img[RD_EOF] = rd_eof_i; // [RULE7]
    next_s.rd_img[RD_EMPTY] = rd_empty_i; // [RULE8]
    next_s.rd_img[RD_SIZE +: 2] = rd_size_i; // [RULE9]

    // Pin synchronisers: a level counts once the last two stages agree
    next_s.md_s = {s.md_s[1:0], mdio_i};
    if (s.md_s[1] == s.md_s[2]) begin
      next_s.md_f = s.md_s[2];
    end
    next_s.ee_s = {s.ee_s[1:0], ee_do_i};
    if (s.ee_s[1] == s.ee_s[2]) begin
      next_s.ee_f = s.ee_s[2];
    end

    if (xfer_done_i) begin
      next_s.xfer = 1'b0; // [RULE2]
    end

    // ****************************************
    // Memory self-test engine
    // ****************************************
    case (s.mode)
      MODE_PAT: bexp = s.baddr[0] ? PAT_ODD : PAT_EVEN;
      MODE_FILL1, MODE_READ1: bexp = '1;
      default: bexp = '0;
    endcase
    case (s.bst)
      B_WR: begin
        next_s.mem_we = 1'b1;
        next_s.mem_addr = s.baddr;
        next_s.mem_wdata = bexp;
        if (qbm_checks(s.mode)) begin
          next_s.bst = B_RD;
        end else begin
          adv = 1'b1;
        end
      end
      B_RD: begin
        next_s.mem_re = 1'b1;
        next_s.mem_addr = s.baddr;
        next_s.bst = B_W1;
      end
      B_W1: next_s.bst = B_CHK;
      B_CHK: begin
        err_n = s.berr | (mem_rdata_i != bexp); // [RULE14]
        next_s.berr = err_n;
        adv = 1'b1;
      end
      default: ;
    endcase
    if (adv) begin
      if (s.baddr == LAST_ADDR) begin
        next_s.bst = B_IDLE;
        next_s.pass = ~err_n; // [RULE11]
        next_s.fail = err_n; // [RULE11]
      end else begin
        next_s.baddr = s.baddr + 1'b1;
        next_s.bst = qbm_fills(s.mode) ? B_WR : B_RD;
      end
    end

    // ****************************************
    // Station management engine
    // ****************************************
    if (s.md_ctl[MC_BUSY] && s.tick) begin
      if (!s.mdc) begin
        next_s.mdc = 1'b1;
        if (!s.md_ctl[MC_WR] && s.md_cnt <= MD_DATA_LEFT) begin
          next_s.md_data = {s.md_data[14:0], s.md_f}; // [RULE20]
        end
        next_s.md_cnt = s.md_cnt - 1'b1;
      end else begin
        next_s.mdc = 1'b0;
        if (s.md_cnt == '0) begin
          next_s.md_ctl[MC_BUSY] = 1'b0; // [RULE19]
          next_s.mdio_oe_n = 1'b1;
          next_s.mdio = 1'b1;
        end else begin
          next_s.md_sh = {s.md_sh[62:0], 1'b0};
          next_s.mdio = s.md_sh[62];
          // Release the line from turnaround on for reads [RULE25]
          next_s.mdio_oe_n = !s.md_ctl[MC_WR] && (s.md_cnt <= MD_TA_LEFT);
        end
      end
    end

    // ****************************************
    // EEPROM engine
    // ****************************************
    if (s.ee_ctl[EC_BUSY] && s.tick) begin
      if (!s.sk) begin
        next_s.sk = 1'b1;
        if (s.ee_ctl[EC_OP +: 2] == OP_READ && s.ee_cnt <= EE_DATA_LEFT) begin
          next_s.ee_data = {s.ee_data[14:0], s.ee_f}; // [RULE22]
        end
        next_s.ee_cnt = s.ee_cnt - 1'b1;
      end else begin
        next_s.sk = 1'b0;
        if (s.ee_cnt == '0) begin
          next_s.ee_ctl[EC_BUSY] = 1'b0; // [RULE23]
          next_s.cs = 1'b0;
          next_s.di = 1'b0;
        end else begin
          next_s.ee_sh = {s.ee_sh[23:0], 1'b0};
          next_s.di = s.ee_sh[23];
        end
      end
    end

    // ****************************************
    // Wishbone slave
    // ****************************************
    case (adr_i)
      ADR_XFER: rimg[XFER_GO] = s.xfer;
      ADR_HEAD: rimg = s.head_img;
      ADR_RDS: rimg = s.rd_img;
      ADR_BCR: rimg = bcr_img;
      ADR_MDD: rimg[15:0] = s.md_data; // [RULE17]
      ADR_MDC: rimg[12:0] = s.md_ctl;
      ADR_EED: rimg[15:0] = s.ee_data;
      ADR_EEC: rimg[8:0] = s.ee_ctl;
      default: rimg = '0;
    endcase
    case (s.wst)
      W_RD1: next_s.wst = W_RD2;
      W_RD2: begin
        next_s.dat = mem_rdata_i; // [RULE16]
        next_s.ack = 1'b1;
        next_s.wst = W_IDLE;
        if (s.auto_inc) begin
          next_s.ram_addr = s.ram_addr + 1'b1; // [RULE12]
        end
      end
      default: begin
        if (bus_req) begin
          next_s.ack = 1'b1;
          next_s.dat = rimg;
          if (adr_i == ADR_BYP && byp_ok) begin
            next_s.mem_addr = s.ram_addr; // [RULE15]
            if (we_i) begin
              next_s.mem_we = 1'b1; // [RULE16]
              next_s.mem_wdata = dat_i;
              if (s.auto_inc) begin
                next_s.ram_addr = s.ram_addr + 1'b1; // [RULE12]
              end
            end else begin
              next_s.ack = 1'b0;
              next_s.mem_re = 1'b1;
              next_s.wst = W_RD1;
            end
          end
          if (we_i) begin
            case (adr_i)
              ADR_XFER: if (sel_i[0] && dat_i[XFER_GO]) next_s.xfer = 1'b1; // [RULE1]
              ADR_DROP: next_s.drop = sel_i[0] & dat_i[DROP_GO]; // [RULE3]
              ADR_BCR: begin
                wv = qbm_merge(bcr_img, dat_i, sel_i);
                next_s.auto_inc = wv[BC_AUTO];
                next_s.bist_en = wv[BC_EN]; // [RULE13]
                next_s.mode = wv[BC_MODE +: 3]; // [RULE14]
                next_s.ram_addr = wv[BC_ADDR +: 14]; // [RULE15]
                // Reserved modes and bypass start nothing
                if (sel_i[3] && dat_i[BC_START] && wv[BC_EN] && s.bst == B_IDLE &&
                    (qbm_fills(wv[BC_MODE +: 3]) || qbm_checks(wv[BC_MODE +: 3]))) begin
                  next_s.baddr = '0; // [RULE10]
                  next_s.berr = 1'b0;
                  next_s.pass = 1'b0;
                  next_s.fail = 1'b0;
                  next_s.bst = qbm_fills(wv[BC_MODE +: 3]) ? B_WR : B_RD;
                end
              end
              ADR_MDD: begin
                wv = qbm_merge({16'h0, s.md_data}, dat_i, sel_i);
                next_s.md_data = wv[15:0]; // [RULE17]
              end
              ADR_MDC: begin
                // Writes while busy are dropped so a frame in flight stays intact [RULE26]
                if (!next_s.md_ctl[MC_BUSY]) begin
                  wv = qbm_merge({19'h0, s.md_ctl}, dat_i, sel_i);
                  next_s.md_ctl = wv[12:0]; // [RULE21]
                  md_frame = {MD_ST, wv[MC_WR] ? MD_OP_WR : MD_OP_RD, wv[MC_PHY +: 5], wv[MC_REG +: 5],
                              wv[MC_WR] ? MD_TA_WR : 2'h0, s.md_data}; // [RULE25] [RULE20] [RULE21]
                  if (wv[MC_BUSY]) begin
                    next_s.md_sh = wv[MC_NOPRE] ? {md_frame, 32'h0} : {MD_PRE, md_frame}; // [RULE18]
                    next_s.md_cnt = wv[MC_NOPRE] ? MD_BITS : MD_BITS_PRE; // [RULE18]
                    next_s.mdio = wv[MC_NOPRE] ? md_frame[31] : MD_PRE[31];
                    next_s.mdio_oe_n = 1'b0;
                    next_s.mdc = 1'b0; // [RULE19]
                  end
                end
              end
              ADR_EED: begin
                wv = qbm_merge({16'h0, s.ee_data}, dat_i, sel_i);
                next_s.ee_data = wv[15:0]; // [RULE22]
              end
              ADR_EEC: begin
                if (!next_s.ee_ctl[EC_BUSY]) begin
                  wv = qbm_merge({23'h0, s.ee_ctl}, dat_i, sel_i);
                  next_s.ee_ctl = wv[8:0];
                  if (wv[EC_BUSY]) begin
                    // Only read and write carry a data phase [RULE24]
                    next_s.ee_sh = {1'b1, wv[EC_OP +: 2], wv[EC_ADDR +: 6], s.ee_data};
                    next_s.ee_cnt = (wv[EC_OP +: 2] == OP_READ || wv[EC_OP +: 2] == OP_WRITE) ?
                                    EE_BITS_DATA : EE_BITS_CMD; // [RULE24]
                    next_s.cs = 1'b1; // [RULE23]
                    next_s.di = 1'b1;
                    next_s.sk = 1'b0;
                  end
                end
              end
              default: ;
            endcase
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= S_RST;
    end else begin
      s <= next_s;
    end
  end

  assign dat_o = s.dat;
  assign ack_o = s.ack;
  assign xfer_req_o = s.xfer;
  assign drop_frame_o = s.drop;
  assign mem_addr_o = s.mem_addr;
  assign mem_wdata_o = s.mem_wdata;
  assign mem_we_o = s.mem_we;
  assign mem_re_o = s.mem_re;
  assign mem_test_o = s.bist_en;
  assign mdc_o = s.mdc;
  assign mdio_o = s.mdio;
  assign mdio_oe_n_o = s.mdio_oe_n;
  assign ee_cs_o = s.cs;
  assign ee_sk_o = s.sk;
  assign ee_di_o = s.di;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence md_launch;
    $rose(s.md_ctl[MC_BUSY]);
  endsequence
  sequence byp_write;
    bus_req && we_i && adr_i == ADR_BYP && byp_ok && s.auto_inc;
  endsequence

  a_xfer_done_clear: assert property ( // [RULE2]
    xfer_done_i && !(bus_req && we_i && adr_i == ADR_XFER) |=> !xfer_req_o)
    else $error("transfer request not cleared on done");
  a_xfer_set: assert property ( // [RULE1]
    bus_req && we_i && adr_i == ADR_XFER && sel_i[0] && dat_i[XFER_GO] |=> xfer_req_o)
    else $error("transfer request not raised");
  a_drop_pulse: assert property ( // [RULE3]
    bus_req && we_i && adr_i == ADR_DROP && sel_i[0] && dat_i[DROP_GO] |=> drop_frame_o ##1 !drop_frame_o)
    else $error("drop pulse wrong");
  // Images taken while in reset hold reset values, so the check starts after release
  a_head_eof: assert property ( // [RULE4]
    !rst_i |=> s.head_img[HD_EOF] == $past(head_eof_i) && s.head_img[HD_NEXT +: 7] == $past(head_next_i))
    else $error("head status not following queue");
  a_rd_empty: assert property ( // [RULE8]
    !rst_i |=> s.rd_img[RD_EMPTY] == $past(rd_empty_i) && s.rd_img[RD_SIZE +: 2] == $past(rd_size_i))
    else $error("data status not following queue");
  a_bist_result: assert property (!(s.pass && s.fail) and (s.bst != B_IDLE |-> !s.pass && !s.fail)) // [RULE11]
    else $error("self-test result inconsistent");
  a_bypass_inc: assert property ( // [RULE12]
    byp_write |=> s.ram_addr == $past(s.ram_addr) + 1'b1 && mem_we_o && mem_addr_o == $past(s.ram_addr))
    else $error("bypass write or address step wrong");
  a_mgmt_first_bit: assert property (md_launch |-> !mdio_oe_n_o && mdio_o == !s.md_ctl[MC_NOPRE]) // [RULE18]
    else $error("management frame first bit wrong");
  a_mgmt_busy_hold: assert property (md_launch |-> s.md_ctl[MC_BUSY] [*8]) // [RULE19]
    else $error("management busy dropped early");
  a_ee_start: assert property ($rose(s.ee_ctl[EC_BUSY]) |-> ee_cs_o && ee_di_o && !ee_sk_o) // [RULE23]
    else $error("eeprom start bit wrong");

endmodule : qbm_regs

// file: verif/qbm_far.sv
/* Far-side model: queue logic, 8-word queue memory, management PHY, EEPROM bit capture.
   Assumes the register block's port timing and a pulled-up data line. */
`timescale 1ns/1ps
module qbm_far #(
  parameter logic [15:0] PHY_WORD = 16'hbeef
) (
  // From the register block
  input wire logic clk_i,
  input wire logic xfer_req_i,
  input wire logic [13:0] mem_addr_i,
  input wire logic [31:0] mem_wdata_i,
  input wire logic mem_we_i,
  input wire logic mem_re_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  input wire logic mdio_oe_n_i,
  input wire logic ee_sk_i,
  input wire logic ee_di_i,
  // Answers
  output logic xfer_done_o,
  output logic [31:0] mem_rdata_o,
  output logic mdio_o
);
  logic [31:0] mem [8];
  logic [4:0] wait_q = 0;
  logic [17:0] out_q = '1;
  logic [31:0] seen_q = 0;
  logic [31:0] ee_q = 0;
  logic mdc_q = 0;
  logic oe_q = 1;
  int rises = 0;
  // Slow move, so the pending bit can be seen
  assign xfer_done_o = (wait_q == 5'h1f);
  assign mdio_o = out_q[17];
  always @(posedge clk_i) begin
    wait_q <= (xfer_req_i && !xfer_done_o) ? wait_q + 5'h1 : 5'h0;
    mdc_q <= mdc_i;
    oe_q <= mdio_oe_n_i;
    if (mem_we_i) mem[mem_addr_i[2:0]] <= mem_wdata_i;
    // Idle read bus toggles so stale data cannot pass
    mem_rdata_o <= mem_re_i ? mem[mem_addr_i[2:0]] : ~mem_rdata_o;
    if (mdio_oe_n_i && !oe_q) out_q <= {2'b10, PHY_WORD};
    else if (mdc_q && !mdc_i) out_q <= {out_q[16:0], 1'b1};
  end
  always @(posedge mdc_i) begin
    rises <= rises + 1;
    seen_q <= {seen_q[30:0], mdio_i};
  end
  always @(posedge ee_sk_i) begin
    ee_q <= {ee_q[30:0], ee_di_i};
  end
endmodule : qbm_far

// file: verif/queue_bist_mgmt_ctl_regs_bench.sv
/* Self-checking bench for the register group over classic Wishbone.
   Assumes qbm_far as partner and an 8-word memory for short self-tests. */
`timescale 1ns/1ps
module queue_bist_mgmt_ctl_regs_bench
  import qbm_pkg::*;
;
  logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0;
  logic [8:0] adr_i = 0;
  logic [31:0] dat_i = 0, dat_o, rdata, wdata, q;
  logic [3:0] sel_i = 4'hf;
  logic ack_o, xreq, xdone, drop, mwe, mre, mdc, mdo, oe_n, phy_o, cs, sk, di, mt;
  logic [13:0] maddr;
  logic eof = 1, trunc = 0, reof = 0, empty = 1;
  logic [6:0] nxt = 0;
  logic [7:0] used = 0;
  logic [1:0] size = 0;
  int mismatches = 0, samples_checked = 0, drops = 0, cycles = 0, r0;
  logic [8:0] ra [8] = '{9'h128, 9'h130, 9'h134, 9'h138, 9'h140, 9'h144, 9'h148, 9'h100};
  logic [31:0] rv [8] = '{0, HEAD_RST, RDS_RST, BCR_RST, 0, 0, 0, 0};
  logic [2:0] md [6] = '{3'h2, 3'h3, 3'h5, 3'h4, 3'h5, 3'h1};
  logic [1:0] mr [6] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h1, 2'h1};
  wire mdio_w = oe_n ? phy_o : mdo;
  always #12.5 clk_i = ~clk_i;
  qbm_regs #(.MEM_WORDS(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .head_eof_i(eof),
    .head_trunc_i(trunc), .head_next_i(nxt), .head_used_i(used), .rd_eof_i(reof), .rd_empty_i(empty),
    .rd_size_i(size), .xfer_done_i(xdone), .xfer_req_o(xreq), .drop_frame_o(drop), .mem_rdata_i(rdata),
    .mem_addr_o(maddr), .mem_wdata_o(wdata), .mem_we_o(mwe), .mem_re_o(mre), .mem_test_o(mt), .mdio_i(mdio_w),
    .mdc_o(mdc), .mdio_o(mdo), .mdio_oe_n_o(oe_n), .ee_do_i(cs), .ee_cs_o(cs), .ee_sk_o(sk), .ee_di_o(di));
  qbm_far far (.clk_i(clk_i), .xfer_req_i(xreq), .mem_addr_i(maddr), .mem_wdata_i(wdata), .mem_we_i(mwe),
    .mem_re_i(mre), .mdc_i(mdc), .mdio_i(mdio_w), .mdio_oe_n_i(oe_n), .xfer_done_o(xdone),
    .mem_rdata_o(rdata), .mdio_o(phy_o), .ee_sk_i(sk), .ee_di_i(di));
  // ****************************************
  // Bus tasks and checks
  // ****************************************
  always @(posedge clk_i) begin
    drops <= drops + drop;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      results();
    end
  end
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask : wb
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    wb(0, a, 0);
    chk(e, q);
  endtask : rd
  task automatic poll(input logic [8:0] a, input int b);
    do wb(0, a, 0); while (q[b] !== 1'b0);
  endtask : poll
  task results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    foreach (ra[i]) rd(ra[i], rv[i]);
    $display("reset test done");
    trunc <= 1;
    eof <= 0;
    nxt <= 7'h55;
    used <= 8'ha5;
    reof <= 1;
    empty <= 0;
    size <= 2'h3;
    @(posedge clk_i);
    rd(ADR_HEAD, 32'h0001_55a5);
    rd(ADR_RDS, 32'h0100_0003);
    wb(1, ADR_XFER, 1);
    rd(ADR_XFER, 1);
    poll(ADR_XFER, 0);
    wb(1, ADR_DROP, 0);
    wb(1, ADR_DROP, 1);
    rd(ADR_DROP, 0);
    chk(1, drops);
    $display("queue test done");
    wb(1, ADR_BCR, 32'h0016_0002);
    wb(1, ADR_BYP, 32'h1234_5678);
    wb(1, ADR_BYP, 32'h9abc_def0);
    rd(ADR_BCR, 32'h2016_0004);
    wb(1, ADR_BCR, 32'h0016_0002);
    rd(ADR_BYP, 32'h1234_5678);
    rd(ADR_BYP, 32'h9abc_def0);
    foreach (md[i]) begin
      wb(1, ADR_BCR, 32'h8018_0000 | {13'h0, md[i], 16'h0});
      do wb(0, ADR_BCR, 0); while (q[30:29] === 2'b00);
      chk({30'h0, mr[i]}, {30'h0, q[30:29]});
    end
    chk(1, mt);
    rd(ADR_BYP, 0);
    wb(1, ADR_BCR, 32'h0016_0001);
    rd(ADR_BYP, PAT_ODD);
    $display("self-test done");
    wb(1, ADR_MDD, 32'h1234);
    r0 = far.rises;
    wb(1, ADR_MDC, 32'h0c62);
    poll(ADR_MDC, MC_BUSY);
    chk(32'h518a_1234, far.seen_q);
    chk(64, far.rises - r0);
    r0 = far.rises;
    wb(1, ADR_MDC, 32'h1862);
    poll(ADR_MDC, MC_BUSY);
    chk(32, far.rises - r0);
    rd(ADR_MDD, 32'hbeef);
    $display("management test done");
    wb(1, ADR_EEC, 32'h0185);
    poll(ADR_EEC, EC_BUSY);
    rd(ADR_EED, 32'hffff);
    chk(32'h0185_0000, far.ee_q);
    wb(1, ADR_EEC, 32'h01c5);
    poll(ADR_EEC, EC_BUSY);
    chk(32'h01c5, {23'h0, far.ee_q[8:0]});
    $display("eeprom test done");
    results();
  end
endmodule : queue_bist_mgmt_ctl_regs_bench
